/* hdl/touch_ctrl.sv */
// Top-level control of an eight-key touch controller: start-up, pin enables,
// guard handling, haptic triggering and the message-pending output.
// Assumes sense and pin levels are asynchronous; SPI clock is a second domain.
module touch_ctrl
  import touch_ctrl_pkg::*;
#(
  parameter longint unsigned SPI_READY_CYCLES = SPI_READY_CYC,
  parameter longint unsigned FULL_READY_CYCLES = FULL_READY_CYC,
  parameter int unsigned BURST_CYCLES = 4096,
  parameter int unsigned MSG_CNT_W = 4
)(
  // System
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reset_pin_n,
  // Configuration storage
  input wire logic nv_valid,
  input wire config_t nv_config,
  input wire config_t default_config,
  // Sensing and pins (asynchronous)
  input wire logic [NUM_KEYS-1:0] key_detect,
  input wire logic [NUM_PINS-1:0] pin_level,
  // Host-side requests from the object map
  input wire logic host_sw_reset,
  input wire logic host_fx_req,
  input wire logic [EFFECT_W-1:0] host_fx,
  input wire logic host_recal,
  // SPI link
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // Message-pending open-drain pin
  output logic msg_pend_o,
  output logic msg_pend_oe,
  // Status and effects
  output logic spi_ready,
  output logic calibrating,
  output logic touch_report_en,
  output logic fully_ready,
  output logic [NUM_KEYS-1:0] key_active,
  output logic [NUM_PINS-1:0] pin_active,
  output run_mode_t run_mode,
  output logic auto_recal,
  output fx_req_t fx_out,
  output logic spread_en
);

  // ****************************************************
  // Elaboration checks
  // ****************************************************
  if (SPI_READY_CYCLES < 1 || FULL_READY_CYCLES <= SPI_READY_CYCLES)
    $error("ready counts must be ordered and nonzero");
  if (BURST_CYCLES < 1 || MSG_CNT_W < 1)
    $error("burst length and message counter width must be nonzero");
  if (CONFIG_LOAD_CYC >= SPI_READY_CYCLES
      || SPI_READY_CYCLES + CAL_BURSTS * BURST_CYCLES >= FULL_READY_CYCLES)
    $error("load and calibration must finish before the ready deadline");

  typedef enum {ST_RESET, ST_LOAD, ST_WAIT_SPI, ST_CAL, ST_RUN} start_state_t;

  function automatic logic [EFFECT_W-1:0] fx_legal(input logic [EFFECT_W-1:0] fx);
    fx_legal = (fx > FX_LAST) ? FX_NONE : fx;
  endfunction

  // ****************************************************
  // Input synchronisers
  // ****************************************************
  logic [1:0] rstpin_s_q;
  logic [NUM_KEYS-1:0] key_s1_q, key_s2_q;
  logic [NUM_PINS-1:0] pin_s1_q, pin_s2_q, pin_prev_q;
  // Two stages for every asynchronous level
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rstpin_s_q <= 2'b00;
      key_s1_q <= '0;
      key_s2_q <= '0;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else
    begin
      rstpin_s_q <= {rstpin_s_q[0], reset_pin_n};
      key_s1_q <= key_detect;
      key_s2_q <= key_s1_q;
      pin_s1_q <= pin_level;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ****************************************************
  // Start-up sequence
  // ****************************************************
  start_state_t state_q;
  logic [31:0] boot_cnt_q;
  logic [31:0] burst_cnt_q;
  logic [4:0] bursts_q;
  config_t cfg_q;
  logic restart;
  logic first_read_q;
  // Pin reset and software reset restart the same sequence as power-on
  assign restart = !rstpin_s_q[1] || host_sw_reset;

  // Sequence: load config, wait for SPI, calibrate, run
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ST_RESET;
      boot_cnt_q <= '0;
      burst_cnt_q <= '0;
      bursts_q <= '0;
    end
    else if (restart)
    begin
      state_q <= ST_RESET;
      boot_cnt_q <= '0;
      burst_cnt_q <= '0;
      bursts_q <= '0;
    end
    else
    begin
      if (boot_cnt_q < 32'(FULL_READY_CYCLES))
        boot_cnt_q <= boot_cnt_q + 32'd1;
      case (state_q)
        ST_RESET: state_q <= ST_LOAD;
        ST_LOAD:
          if (boot_cnt_q >= 32'(CONFIG_LOAD_CYC))
            state_q <= ST_WAIT_SPI;
        ST_WAIT_SPI:
          if (boot_cnt_q >= 32'(SPI_READY_CYCLES - 1))
            state_q <= ST_CAL;
        ST_CAL:
        begin
          // Calibration counts whole bursts; recal requests restart it
          if (burst_cnt_q == 32'(BURST_CYCLES - 1))
          begin
            burst_cnt_q <= '0;
            bursts_q <= bursts_q + 5'd1;
            if (bursts_q == 5'(CAL_BURSTS - 1))
              state_q <= ST_RUN;
          end
          else
            burst_cnt_q <= burst_cnt_q + 32'd1;
        end
        ST_RUN:
          if (host_recal || auto_recal)
          begin
            state_q <= ST_CAL;
            bursts_q <= '0;
          end
        default: state_q <= ST_RESET;
      endcase
    end
  end

  // Configuration capture: saved values if present, else defaults
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      cfg_q <= '0;
    else if (state_q == ST_LOAD)
      cfg_q <= nv_valid ? nv_config : default_config;
  end

  // ****************************************************
  // Status outputs
  // ****************************************************
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      spi_ready <= 1'b0;
      calibrating <= 1'b0;
      touch_report_en <= 1'b0;
      fully_ready <= 1'b0;
      spread_en <= 1'b0;
    end
    else
    begin
      spi_ready <= !restart && (state_q == ST_CAL || state_q == ST_RUN);
      calibrating <= !restart && state_q == ST_CAL;
      touch_report_en <= !restart && state_q == ST_RUN;
      // Full function only once calibrated; the elaboration check keeps it in time
      fully_ready <= !restart && state_q == ST_RUN;
      spread_en <= 1'b1;
    end
  end

  // ****************************************************
  // Key, pin, guard and mode control
  // ****************************************************
  logic [NUM_KEYS-1:0] live_keys, guard_hits, real_hits;
  logic [31:0] hold_cnt_q;
  // Shared pins only usable when their key is disabled
  logic [NUM_PINS-1:0] pin_avail;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++)
    begin : g_pin
      if (gi < NUM_PINS_DEDICATED)
        assign pin_avail[gi] = cfg_q.pin_enable[gi];
      else
        assign pin_avail[gi] = cfg_q.pin_enable[gi]
          && !cfg_q.key_enable[NUM_KEYS - 1 - (gi - NUM_PINS_DEDICATED)];
    end
  endgenerate
  assign live_keys = touch_report_en ? (key_s2_q & cfg_q.key_enable) : '0;
  assign guard_hits = live_keys & cfg_q.guard_key;
  assign real_hits = live_keys & ~cfg_q.guard_key;

  // Mode selection from the power cycle setting and detections
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      run_mode <= MODE_SLEEP;
      key_active <= '0;
      pin_active <= '0;
    end
    else
    begin
      key_active <= cfg_q.key_enable;
      pin_active <= pin_avail;
      if (cfg_q.cycle_time == CYCLE_SLEEP)
        run_mode <= MODE_SLEEP;
      else if (|real_hits)
        run_mode <= MODE_ACTIVE;
      else if (cfg_q.cycle_time == CYCLE_FREE_RUN)
        run_mode <= MODE_FREE_RUN;
      else
        run_mode <= MODE_IDLE;
    end
  end

  // Long touch timer; guard detections are excluded from it
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hold_cnt_q <= '0;
      auto_recal <= 1'b0;
    end
    else
    begin
      auto_recal <= 1'b0;
      if (!(|real_hits))
        hold_cnt_q <= '0;
      else if (hold_cnt_q == 32'(FULL_READY_CYCLES - 1))
      begin
        hold_cnt_q <= '0;
        auto_recal <= 1'b1;
      end
      else
        hold_cnt_q <= hold_cnt_q + 32'd1;
    end
  end

  // ****************************************************
  // Haptic triggers
  // ****************************************************
  logic [NUM_KEYS-1:0] hits_prev_q;
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hits_prev_q <= '0;
      pin_prev_q <= '0;
      fx_out <= '0;
    end
    else
    begin
      hits_prev_q <= real_hits;
      pin_prev_q <= pin_s2_q;
      // Host request wins over event triggers in the same cycle
      if (host_fx_req && spi_ready)
        fx_out <= '{valid: 1'b1, effect: fx_legal(host_fx)};
      else if (|(real_hits & ~hits_prev_q))
        fx_out <= '{valid: 1'b1, effect: fx_legal(cfg_q.fx_touch)};
      else if (touch_report_en && |((pin_s2_q ^ pin_prev_q) & pin_avail))
        fx_out <= '{valid: 1'b1, effect: fx_legal(cfg_q.fx_pin)};
      else
        fx_out <= '0;
    end
  end

  // ****************************************************
  // SPI link domain
  // ****************************************************
  logic [7:0] shift_q;
  logic [2:0] bit_q;
  logic read_tgl_q;
  logic [1:0] spi_en_s_q;
  logic frame_rst;
  // Deselect clears framing at once, since the link clock stops between frames
  assign frame_rst = sys_rst || ss_n;
  // SPI enable crosses into the link domain on two flops
  always_ff @(posedge sck or posedge sys_rst)
  begin
    if (sys_rst)
      spi_en_s_q <= 2'b00;
    else
      spi_en_s_q <= {spi_en_s_q[0], spi_ready};
  end
  // Bit capture on rising SCK; a partial byte dies with its frame
  always_ff @(posedge sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      shift_q <= '0;
      bit_q <= '0;
    end
    else
    begin
      shift_q <= {shift_q[6:0], mosi};
      bit_q <= bit_q + 3'd1;
    end
  end
  // A whole read command byte flips the toggle; readiness is judged system side
  always_ff @(posedge sck or posedge sys_rst)
  begin
    if (sys_rst)
      read_tgl_q <= 1'b0;
    else if (!ss_n && bit_q == 3'd7 && {shift_q[6:0], mosi} == SPI_MSG_READ)
      read_tgl_q <= ~read_tgl_q;
  end
  // MISO changes on falling SCK; floats while deselected
  always_ff @(negedge sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end
    else
    begin
      miso <= shift_q[7];
      miso_oe <= spi_en_s_q[1];
    end
  end

  // ****************************************************
  // Message pending
  // ****************************************************
  logic [2:0] rd_s_q;
  logic [MSG_CNT_W-1:0] msg_cnt_q;
  logic rd_evt;
  logic rd_ok;
  assign rd_evt = rd_s_q[2] ^ rd_s_q[1];
  // Reads before the link is ready are ignored
  assign rd_ok = rd_evt && spi_ready;
  // Message count: detections add, reads remove; pin also held until the first read
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_s_q <= '0;
      msg_cnt_q <= '0;
      first_read_q <= 1'b0;
      msg_pend_o <= 1'b0;
      msg_pend_oe <= 1'b0;
    end
    else
    begin
      rd_s_q <= {rd_s_q[1:0], read_tgl_q};
      msg_pend_o <= 1'b0;
      if (restart || state_q == ST_RESET || state_q == ST_LOAD)
      begin
        msg_cnt_q <= '0;
        first_read_q <= 1'b0;
        msg_pend_oe <= 1'b0;
      end
      else
      begin
        if (rd_ok)
          first_read_q <= 1'b1;
        // A detection with a simultaneous read leaves a nonzero count below full unchanged; detections at a full count are dropped
        if (|(real_hits & ~hits_prev_q) && msg_cnt_q != '1)
          msg_cnt_q <= msg_cnt_q + MSG_CNT_W'(!(rd_ok && msg_cnt_q != '0));
        else if (rd_ok && msg_cnt_q != '0)
          msg_cnt_q <= msg_cnt_q - MSG_CNT_W'(1);
        // Low until first read, then low while messages wait; release on read
        msg_pend_oe <= (!first_read_q && !rd_ok)
          || (msg_cnt_q != '0 && !rd_ok);
      end
    end
  end

endmodule // touch_ctrl

/* hdl/touch_ctrl_pkg.sv */
// Package for the touch controller start-up and top-level control.
// Assumes a 50 MHz system clock and an SPI link clock from the host.
package touch_ctrl_pkg;

  // ****************************************************
  // Sizes
  // ****************************************************
  localparam int unsigned NUM_KEYS = 8;
  localparam int unsigned NUM_PINS_DEDICATED = 12;
  localparam int unsigned NUM_PINS_SHARED = 4;
  localparam int unsigned NUM_PINS = NUM_PINS_DEDICATED + NUM_PINS_SHARED;
  localparam int unsigned NUM_EFFECTS = 16;
  localparam int unsigned EFFECT_W = 4;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam longint unsigned CLK_HZ = 50_000_000;
  localparam longint unsigned SPI_READY_MS = 50;
  localparam longint unsigned FULL_READY_MS = 200;
  localparam longint unsigned CONFIG_LOAD_US = 100;
  localparam int unsigned CAL_BURSTS = 15;
  localparam longint unsigned SPI_READY_CYC = SPI_READY_MS * CLK_HZ / 1000;
  localparam longint unsigned FULL_READY_CYC = FULL_READY_MS * CLK_HZ / 1000;
  localparam longint unsigned CONFIG_LOAD_CYC = CONFIG_LOAD_US * CLK_HZ / 1_000_000;

  // ****************************************************
  // Power cycle codes and the effect library
  // ****************************************************
  localparam logic [7:0] CYCLE_SLEEP = 8'h00;
  localparam logic [7:0] CYCLE_FREE_RUN = 8'hff;
  localparam logic [EFFECT_W-1:0] FX_NONE = 4'h0;
  localparam logic [EFFECT_W-1:0] FX_LAST = 4'he; // 14 library effects, 1..14
  localparam logic [7:0] SPI_MSG_READ = 8'h01;   // Command byte that consumes a message

  typedef enum logic [1:0] {MODE_SLEEP, MODE_IDLE, MODE_ACTIVE, MODE_FREE_RUN} run_mode_t;

  // Configuration as loaded from storage
  typedef struct packed {
    logic [NUM_KEYS-1:0] key_enable;
    logic [NUM_PINS-1:0] pin_enable;
    logic [NUM_KEYS-1:0] guard_key;
    logic [7:0] cycle_time;
    logic [EFFECT_W-1:0] fx_touch;
    logic [EFFECT_W-1:0] fx_pin;
  } config_t;

  // Haptic request to the effect engine
  typedef struct packed {
    logic valid;
    logic [EFFECT_W-1:0] effect;
  } fx_req_t;

endpackage

/* bench/touch_ctrl_assertions.sv */
// Checker for touch_ctrl: reset quiet, pending pin, effects, modes.
// Sees only the top ports; bound to every touch_ctrl instance.
module touch_ctrl_assertions
  import touch_ctrl_pkg::*;
(
  // System
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reset_pin_n,
  input wire logic host_sw_reset,
  // Configuration and host requests
  input wire logic nv_valid,
  input wire config_t nv_config,
  input wire config_t default_config,
  input wire logic host_fx_req,
  input wire logic [EFFECT_W-1:0] host_fx,
  // Observed outputs
  input wire logic msg_pend_o,
  input wire logic msg_pend_oe,
  input wire logic spi_ready,
  input wire logic calibrating,
  input wire logic touch_report_en,
  input wire logic fully_ready,
  input wire run_mode_t run_mode,
  input wire fx_req_t fx_out,
  input wire logic spread_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [7:0] cyc;
  // Cycle setting in force
  assign cyc = nv_valid ? nv_config.cycle_time : default_config.cycle_time;
  // ****************
  // Effect request steps
  // ****************
  sequence fx_take;
    host_fx_req && spi_ready && host_fx != FX_NONE && host_fx <= FX_LAST;
  endsequence
  sequence fx_give(logic [EFFECT_W-1:0] e);
    fx_out.valid && fx_out.effect == e;
  endsequence
  // Mode checks wait for a settled setting, so a restart never trips them
  sequence cyc_settled;
    $stable(cyc) [*8];
  endsequence
  reset_quiet_a: assert property (disable iff (1'b0)
    sys_rst |-> !msg_pend_oe && !spi_ready && !fully_ready) else $error("output live in reset");
  pend_drive_a: assert property (msg_pend_oe |-> !msg_pend_o)
    else $error("pending pin driven high");
  spread_on_a: assert property (!$past(sys_rst) |-> spread_en)
    else $error("spreading off");
  fx_play_a: assert property (fx_take |=> fx_give($past(host_fx)))
    else $error("host effect lost");
  fx_clip_a: assert property (host_fx_req && spi_ready && host_fx > FX_LAST
    |=> fx_give(FX_NONE)) else $error("bad effect code passed");
  cal_quiet_a: assert property (calibrating |-> !touch_report_en && !fully_ready)
    else $error("report during calibration");
  ready_order_a: assert property (fully_ready |-> spi_ready && touch_report_en)
    else $error("ready before link");
  sleep_mode_a: assert property (cyc_settled ##0 fully_ready && cyc == CYCLE_SLEEP
    |-> run_mode == MODE_SLEEP) else $error("sleep setting ignored");
  free_mode_a: assert property (cyc_settled ##0 fully_ready && cyc == CYCLE_FREE_RUN
    |-> run_mode == MODE_FREE_RUN) else $error("free-run setting ignored");
  sw_restart_a: assert property (host_sw_reset |-> ##[1:3] !fully_ready)
    else $error("soft reset ignored");
  pin_restart_a: assert property ($fell(reset_pin_n) ##1 !reset_pin_n [*2]
    |-> ##[0:2] !fully_ready) else $error("pin reset ignored");
endmodule // touch_ctrl_assertions

bind touch_ctrl touch_ctrl_assertions chk (.clock(clock), .sys_rst(sys_rst),
  .reset_pin_n(reset_pin_n), .host_sw_reset(host_sw_reset), .nv_valid(nv_valid),
  .nv_config(nv_config), .default_config(default_config), .host_fx_req(host_fx_req),
  .host_fx(host_fx), .msg_pend_o(msg_pend_o), .msg_pend_oe(msg_pend_oe),
  .spi_ready(spi_ready), .calibrating(calibrating), .touch_report_en(touch_report_en),
  .fully_ready(fully_ready), .run_mode(run_mode), .fx_out(fx_out), .spread_en(spread_en));

/* bench/spi_host_model.sv */
// Behavioural host acting as link master, one byte per frame.
// Link clock runs only inside a frame, half period 15 ns.
module spi_host_model (
  // Link
  output logic sck,
  output logic ss_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q;
  initial
  begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  // Gap sets a prompt or a slow host
  task automatic send(input logic [7:0] b, input int gap);
    #7 ss_n = 1'b0;
    #(gap);
    for (int i = 7; i >= 0; i--)
    begin
      mosi = b[i];
      #15 sck = 1'b1;
      rx_q = {rx_q[6:0], miso & miso_oe};
      #15 sck = 1'b0;
    end
    #(gap) ss_n = 1'b1;
    mosi = ~mosi; // Released line must not look held
  endtask
endmodule // spi_host_model

/* bench/tb.sv */
// Self-checking bench for touch_ctrl with a behavioural link host.
// Long counts shortened through the top parameters.
module tb
  import touch_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, sys_rst, reset_pin_n, nv_valid, host_sw_reset, host_fx_req, host_recal;
  logic sck, ss_n, mosi, miso, miso_oe, msg_pend_o, msg_pend_oe, spi_ready;
  logic calibrating, touch_report_en, fully_ready, auto_recal, spread_en, seen_q;
  config_t nv_config, default_config, cfg;
  logic [NUM_KEYS-1:0] key_detect, key_active;
  logic [NUM_PINS-1:0] pin_level, pin_active;
  logic [EFFECT_W-1:0] host_fx;
  logic [EFFECT_W-1:0] exp_q[$];
  run_mode_t run_mode, mode;
  fx_req_t fx_out;
  int n_fail, samples_checked, seed, k;
  // ****************
  // Clock, design and host
  // ****************
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  touch_ctrl #(.SPI_READY_CYCLES(5100), .FULL_READY_CYCLES(5200), .BURST_CYCLES(4)) dut (
    .clock(clock), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .nv_valid(nv_valid),
    .nv_config(nv_config), .default_config(default_config), .key_detect(key_detect),
    .pin_level(pin_level), .host_sw_reset(host_sw_reset), .host_fx_req(host_fx_req),
    .host_fx(host_fx), .host_recal(host_recal), .sck(sck), .ss_n(ss_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .msg_pend_o(msg_pend_o), .msg_pend_oe(msg_pend_oe),
    .spi_ready(spi_ready), .calibrating(calibrating), .touch_report_en(touch_report_en),
    .fully_ready(fully_ready), .key_active(key_active), .pin_active(pin_active),
    .run_mode(run_mode), .auto_recal(auto_recal), .fx_out(fx_out), .spread_en(spread_en));
  spi_host_model host (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Restart, then check the start-up result against the loaded setting
  task automatic restart(input logic nv, input logic [7:0] c, input logic by_pin);
    @(posedge clock);
    nv_valid <= nv;
    nv_config.cycle_time <= c;
    default_config.cycle_time <= c;
    if (by_pin)
      reset_pin_n <= 1'b0;
    else
      host_sw_reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset_pin_n <= 1'b1;
    host_sw_reset <= 1'b0;
    repeat (6) @(posedge clock);
    for (k = 0; k < 8000 && fully_ready !== 1'b1; k++) @(posedge clock);
    cfg = nv_valid ? nv_config : default_config;
    mode = c == CYCLE_SLEEP ? MODE_SLEEP : c == CYCLE_FREE_RUN ? MODE_FREE_RUN : MODE_IDLE;
    check(fully_ready, 1);
    check(msg_pend_oe, 1);
    check(msg_pend_o, 0);
    check(run_mode, mode);
    check(key_active, cfg.key_enable);
    check(pin_active[11:0], cfg.pin_enable[11:0]);
    check(spread_en, 1);
    $display("restart done");
  endtask
  // Effect results are matched against the oldest note
  always @(posedge clock)
    if (fx_out.valid === 1'b1 && exp_q.size() > 0)
      check(fx_out.effect, exp_q.pop_front());
  always @(posedge clock)
    if (auto_recal === 1'b1)
      seen_q <= 1'b1;
  initial
  begin
    #800000;
    n_fail++;
    $display("[FAIL] t=%0t watchdog", $time);
    end_of_test;
  end
  // ****************
  // Main sequence
  // ****************
  initial
  begin
    seed = 6;
    n_fail = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    reset_pin_n = 1'b1;
    host_sw_reset = 1'b0;
    host_fx_req = 1'b0;
    host_fx = 4'h0;
    host_recal = 1'b0;
    key_detect = 8'h00;
    pin_level = 16'($random(seed));
    nv_valid = 1'b1;
    nv_config = config_t'(48'({$random(seed), $random(seed)}));
    default_config = config_t'(48'({$random(seed), $random(seed)}));
    nv_config.key_enable = 8'hff;
    nv_config.guard_key = 8'h01;
    nv_config.pin_enable = 16'hffff;
    nv_config.fx_pin = 4'h3;
    repeat (2) @(posedge clock);
    check(msg_pend_oe, 0);
    check(miso_oe, 0);
    @(posedge clock);
    sys_rst <= 1'b0;
    restart(1'b1, 8'h10, 1'b0);
    // Guard held past the long-touch time
    seen_q = 1'b0;
    key_detect <= 8'h01;
    repeat (5300) @(posedge clock);
    check(run_mode, MODE_IDLE);
    check(seen_q, 0);
    key_detect <= 8'h00;
    host_recal <= 1'b1;
    @(posedge clock);
    host_recal <= 1'b0;
    repeat (2) @(posedge clock);
    check(calibrating, 1);
    repeat (80) @(posedge clock);
    check(touch_report_en, 1);
    $display("guard done");
    // Codes 1 to 15 back to back; codes past the library become none
    for (int c = 1; c < 16; c++)
    begin
      exp_q.push_back(c > 14 ? FX_NONE : 4'(c));
      host_fx_req <= 1'b1;
      host_fx <= 4'(c);
      @(posedge clock);
    end
    host_fx_req <= 1'b0;
    exp_q.push_back(4'h3);
    pin_level[0] <= ~pin_level[0];
    repeat (20) @(posedge clock);
    check(exp_q.size(), 0);
    $display("effects done");
    // Only the read command releases pending
    host.send(8'h02, 20);
    repeat (20) @(posedge clock);
    check(msg_pend_oe, 1);
    host.send(8'h01, 400);
    seen_q = 1'b1;
    for (k = 0; k < 100; k++)
    begin
      if (msg_pend_oe === 1'b0)
        seen_q = 1'b0;
      @(posedge clock);
    end
    check(seen_q, 0);
    // A new message pulls the pin again; reading it releases it
    key_detect <= 8'h02;
    repeat (10) @(posedge clock);
    check(msg_pend_oe, 1);
    key_detect <= 8'h00;
    host.send(8'h01, 400);
    check(msg_pend_oe, 0);
    $display("pending done");
    restart(1'b0, CYCLE_SLEEP, 1'b1);
    restart(1'b1, CYCLE_FREE_RUN, 1'b0);
    end_of_test;
  end
endmodule // tb
